// ===== rtl/ceb_exc_unit.sv
/*
 * Exception entry and return, status words, debug halt and bus arbiter.
 * Assumes the pipeline stalls while halted and obeys the grants given.
 */
`timescale 1ns/1ps
module ceb_exc_unit #(
   parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Exception sources
   input wire logic irq_req,
   input wire logic fast_interrupt_req,
   input wire logic abort_req,
   input wire logic undef_req,
   input wire logic software_trap_req,
   input wire logic [31:0] ret_addr,
   input wire logic exc_return,
   output logic exc_taken,
   output ceb_pkg::ceb_exc_t exc_kind,
   // Core register access
   input wire logic [3:0] rd_idx_a,
   input wire logic [3:0] rd_idx_b,
   output logic [31:0] rd_data_a,
   output logic [31:0] rd_data_b,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic pc_wr_en,
   input wire logic [31:0] pc_wr_data,
   output logic [31:0] pc,
   // Status words
   input wire logic status_wr_en,
   input wire ceb_pkg::ceb_status_t status_wr_data,
   output ceb_pkg::ceb_status_t current_program_status,
   output ceb_pkg::ceb_status_t saved_status,
   // Shared bus, core side
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_gnt,
   input wire logic data_req,
   input wire ceb_pkg::ceb_bus_req_t data_cmd,
   output logic data_gnt,
   // Shared bus, memory side
   output logic bus_valid,
   output ceb_pkg::ceb_bus_req_t bus_cmd,
   output logic [3:0] bus_be,
   input wire logic bus_ready,
   // Debug port
   input wire logic dbg_wr,
   input wire logic [1:0] dbg_sel,
   input wire logic [31:0] dbg_wdata,
   input wire logic dbg_resume,
   input wire logic [3:0] dbg_reg_idx,
   output logic [31:0] dbg_reg_data,
   input wire logic dbg_mem_req,
   input wire ceb_pkg::ceb_bus_req_t dbg_mem_cmd,
   output logic dbg_mem_gnt,
   output logic halted
);

   ceb_pkg::ceb_status_t status_q;
   ceb_pkg::ceb_status_t saved_q [ceb_pkg::NUM_SAVED];
   ceb_pkg::ceb_state_t state_q;
   ceb_pkg::ceb_exc_t take;
   ceb_pkg::ceb_mode_t take_mode;
   logic abort_pend_q, undef_pend_q, trap_pend_q;
   logic exc_taken_q;
   ceb_pkg::ceb_exc_t exc_kind_q;
   logic [31:0] bkpt_addr_q, watch_addr_q, dbg_reg_q;
   logic bkpt_arm_q, watch_arm_q, skip_bkpt_q;
   logic bkpt_hit, watch_hit, running, entering, has_saved;
   logic [2:0] saved_slot;
   logic [3:0] rf_idx_b;
   ceb_pkg::ceb_bus_req_t sel_cmd;

   assign running = (state_q == ceb_pkg::ST_RUN);
   assign halted = !running;

   // ---------------------------------------------------------------
   // Exception selection
   // ---------------------------------------------------------------
   // five kinds with their modes
   always_comb begin
      take = ceb_pkg::EXC_NONE;
      take_mode = status_q.mode;
      if (abort_pend_q) begin
         take = ceb_pkg::EXC_ABORT;
         take_mode = ceb_pkg::MODE_ABORT;
      end else if (fast_interrupt_req && !status_q.fast_mask) begin
         take = ceb_pkg::EXC_FAST;
         take_mode = ceb_pkg::MODE_FAST;
      end else if (irq_req && !status_q.irq_mask) begin
         take = ceb_pkg::EXC_IRQ;
         take_mode = ceb_pkg::MODE_IRQ;
      end else if (undef_pend_q) begin
         take = ceb_pkg::EXC_UNDEF;
         take_mode = ceb_pkg::MODE_UNDEF;
      end else if (trap_pend_q) begin
         take = ceb_pkg::EXC_TRAP;
         take_mode = ceb_pkg::MODE_TRAP;
      end
      if (!running) begin
         take = ceb_pkg::EXC_NONE;
         take_mode = status_q.mode;
      end
   end

   assign entering = (take != ceb_pkg::EXC_NONE);

   // Event pulses are held until serviced; a new event beats the clear.
   always_ff @(posedge clk) begin
      if (reset) begin
         abort_pend_q <= 1'b0;
         undef_pend_q <= 1'b0;
         trap_pend_q <= 1'b0;
      end else begin
         abort_pend_q <= abort_req
            || (abort_pend_q && take != ceb_pkg::EXC_ABORT);
         undef_pend_q <= undef_req
            || (undef_pend_q && take != ceb_pkg::EXC_UNDEF);
         trap_pend_q <= software_trap_req
            || (trap_pend_q && take != ceb_pkg::EXC_TRAP);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         exc_taken_q <= 1'b0;
         exc_kind_q <= ceb_pkg::EXC_NONE;
      end else begin
         exc_taken_q <= entering;
         exc_kind_q <= take;
      end
   end

   assign exc_taken = exc_taken_q;
   assign exc_kind = exc_kind_q;

   // ---------------------------------------------------------------
   // Status words
   // ---------------------------------------------------------------
   // Modes one to five own a saved copy; user and system have none.
   assign has_saved = status_q.mode != ceb_pkg::MODE_USER
                   && status_q.mode != ceb_pkg::MODE_SYSTEM;
   assign saved_slot = 3'(status_q.mode - ceb_pkg::MODE_FAST);

   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= ceb_pkg::STATUS_RESET;
      end else if (entering) begin
         status_q.mode <= take_mode;
         status_q.compact <= 1'b0;
         status_q.irq_mask <= 1'b1;
         if (take == ceb_pkg::EXC_FAST) begin
            status_q.fast_mask <= 1'b1;
         end
      end else if (exc_return && has_saved && running) begin
         status_q <= saved_q[saved_slot];
      end else if (status_wr_en && running) begin
         if (status_q.mode == ceb_pkg::MODE_USER) begin
            status_q.flags <= status_wr_data.flags;
         end else begin
            status_q <= status_wr_data;
            status_q.rsvd <= '0;
         end
      end
   end

   generate
      for (genvar s = 0; s < ceb_pkg::NUM_SAVED; s++) begin : g_saved
         always_ff @(posedge clk) begin
            if (reset) begin
               saved_q[s] <= ceb_pkg::STATUS_RESET;
            end else if (entering
                         && 3'(take_mode - ceb_pkg::MODE_FAST) == 3'(s)) begin
               saved_q[s] <= status_q;
            end
         end
      end
   endgenerate

   assign current_program_status = status_q;
   assign saved_status = has_saved ? saved_q[saved_slot] : '0;

   // ---------------------------------------------------------------
   // Banked register file
   // ---------------------------------------------------------------
   assign rf_idx_b = running ? rd_idx_b : dbg_reg_idx;

   // link written in the new mode
   ceb_bank_rf #(
      .WIDTH(32),
      .DEPTH(ceb_pkg::NUM_GP)
   ) u_rf (
      .clk(clk),
      .reset(reset),
      .mode(status_q.mode),
      .rd_idx_a(rd_idx_a),
      .rd_idx_b(rf_idx_b),
      .rd_data_a(rd_data_a),
      .rd_data_b(rd_data_b),
      .wr_en(entering || (wr_en && running)),
      .wr_mode(entering ? take_mode : status_q.mode),
      .wr_idx(entering ? ceb_pkg::IDX_LR : wr_idx),
      .wr_data(entering ? ret_addr : wr_data),
      .pc_wr_en(entering || (pc_wr_en && running)),
      .pc_wr_data(entering ? VEC_BASE + {27'h0, take, ceb_pkg::VEC_SHIFT_PAD}
                           : pc_wr_data),
      .pc(pc)
   );

   // ---------------------------------------------------------------
   // Debug comparators and halt
   // ---------------------------------------------------------------
   // only the debug port programs these
   always_ff @(posedge clk) begin
      if (reset) begin
         bkpt_addr_q <= '0;
         watch_addr_q <= '0;
         bkpt_arm_q <= 1'b0;
         watch_arm_q <= 1'b0;
      end else if (dbg_wr) begin
         case (dbg_sel)
            ceb_pkg::DBG_BKPT_ADDR: bkpt_addr_q <= dbg_wdata;
            ceb_pkg::DBG_BKPT_CTRL: begin
               bkpt_arm_q <= dbg_wdata[ceb_pkg::CTRL_ARM_BIT];
            end
            ceb_pkg::DBG_WATCH_ADDR: watch_addr_q <= dbg_wdata;
            default: begin
               watch_arm_q <= dbg_wdata[ceb_pkg::CTRL_ARM_BIT];
            end
         endcase
      end
   end

   // A breakpoint stops the fetch before it reaches the bus; the skip
   // flag lets the same fetch through once after a resume.
   assign bkpt_hit = running && fetch_req && !data_req && bkpt_arm_q
                  && !skip_bkpt_q && fetch_addr == bkpt_addr_q;
   assign watch_hit = data_gnt && watch_arm_q
                   && data_cmd.addr == watch_addr_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ceb_pkg::ST_RUN;
      end else begin
         case (state_q)
            ceb_pkg::ST_RUN: begin
               if (bkpt_hit || watch_hit) begin
                  state_q <= ceb_pkg::ST_HALT;
               end
            end
            ceb_pkg::ST_HALT: begin
               if (dbg_resume) begin
                  state_q <= ceb_pkg::ST_RUN;
               end
            end
            default: state_q <= ceb_pkg::ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         skip_bkpt_q <= 1'b0;
      end else if (halted && dbg_resume) begin
         skip_bkpt_q <= 1'b1;
      end else if (fetch_gnt) begin
         skip_bkpt_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dbg_reg_q <= '0;
      end else if (halted) begin
         dbg_reg_q <= rd_data_b;
      end
   end

   assign dbg_reg_data = dbg_reg_q;

   // ---------------------------------------------------------------
   // Shared bus arbiter
   // ---------------------------------------------------------------
   // one bus, data before fetch
   always_comb begin
      sel_cmd = data_cmd;
      bus_valid = 1'b0;
      if (halted) begin
         sel_cmd = dbg_mem_cmd;
         bus_valid = dbg_mem_req;
      end else if (data_req) begin
         bus_valid = 1'b1;
      end else begin
         sel_cmd = '{addr: fetch_addr, wdata: 32'h0000_0000, we: 1'b0,
                     size: ceb_pkg::SIZE_WORD};
         bus_valid = fetch_req && !bkpt_hit;
      end
   end

   always_comb begin
      case (sel_cmd.size)
         ceb_pkg::SIZE_BYTE: bus_be = 4'b0001 << sel_cmd.addr[1:0];
         ceb_pkg::SIZE_HALF: bus_be = sel_cmd.addr[1] ? 4'b1100 : 4'b0011;
         default: bus_be = 4'b1111;
      endcase
   end

   assign bus_cmd = sel_cmd;
   assign dbg_mem_gnt = halted && dbg_mem_req && bus_ready;
   assign data_gnt = running && data_req && bus_ready;
   assign fetch_gnt = running && !data_req && bus_valid && bus_ready;

endmodule : ceb_exc_unit

// ===== rtl/ceb_pkg.sv
/*
 * Shared constants and types for the exception and banked register unit.
 * Assumes one core clock and a synchronous active-high reset.
 */
package ceb_pkg;

   // ---------------------------------------------------------------
   // Register file sizes
   // ---------------------------------------------------------------
   localparam int NUM_GP = 31;
   localparam int NUM_SAVED = 5;
   localparam logic [3:0] IDX_FAST_LO = 4'h8;
   localparam logic [3:0] IDX_SP = 4'hD;
   localparam logic [3:0] IDX_LR = 4'hE;
   localparam logic [3:0] IDX_PC = 4'hF;
   localparam logic [4:0] PHYS_FAST_BASE = 5'h10;
   localparam logic [4:0] PHYS_BANK_BASE = 5'h17;

   // ---------------------------------------------------------------
   // Modes, exceptions and status word
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_USER   = 3'b000,
      MODE_FAST   = 3'b001,
      MODE_IRQ    = 3'b010,
      MODE_ABORT  = 3'b011,
      MODE_UNDEF  = 3'b100,
      MODE_TRAP   = 3'b101,
      MODE_SYSTEM = 3'b110
   } ceb_mode_t;

   typedef enum logic [2:0] {
      EXC_NONE  = 3'b000,
      EXC_ABORT = 3'b001,
      EXC_FAST  = 3'b010,
      EXC_IRQ   = 3'b011,
      EXC_UNDEF = 3'b100,
      EXC_TRAP  = 3'b101
   } ceb_exc_t;

   typedef struct packed {
      logic [3:0] flags;
      logic [21:0] rsvd;
      logic irq_mask;
      logic fast_mask;
      logic compact;
      ceb_mode_t mode;
   } ceb_status_t;

   localparam ceb_status_t STATUS_RESET = '{flags: 4'h0, rsvd: 22'h0,
      irq_mask: 1'b1, fast_mask: 1'b1, compact: 1'b0, mode: MODE_TRAP};

   // ---------------------------------------------------------------
   // Shared bus
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_HALF = 2'b01,
      SIZE_WORD = 2'b10
   } ceb_size_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic we;
      ceb_size_t size;
   } ceb_bus_req_t;

   localparam logic [1:0] VEC_SHIFT_PAD = 2'b00;

   // ---------------------------------------------------------------
   // Debug comparator slots
   // ---------------------------------------------------------------
   localparam logic [1:0] DBG_BKPT_ADDR = 2'd0;
   localparam logic [1:0] DBG_BKPT_CTRL = 2'd1;
   localparam logic [1:0] DBG_WATCH_ADDR = 2'd2;
   localparam logic [1:0] DBG_WATCH_CTRL = 2'd3;
   localparam int CTRL_ARM_BIT = 0;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HALT = 1'b1
   } ceb_state_t;

endpackage : ceb_pkg

// ===== rtl/ceb_bank_rf.sv
/*
 * Banked general register file: 31 physical words, mode-mapped views.
 * Assumes index and mode inputs are stable in the cycle they are used.
 */
`timescale 1ns/1ps
module ceb_bank_rf #(
   parameter int WIDTH = 32,
   parameter int DEPTH = ceb_pkg::NUM_GP
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Read ports, viewed through the current mode
   input wire ceb_pkg::ceb_mode_t mode,
   input wire logic [3:0] rd_idx_a,
   input wire logic [3:0] rd_idx_b,
   output logic [WIDTH-1:0] rd_data_a,
   output logic [WIDTH-1:0] rd_data_b,
   // General write port with its own mode view
   input wire logic wr_en,
   input wire ceb_pkg::ceb_mode_t wr_mode,
   input wire logic [3:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Program counter port
   input wire logic pc_wr_en,
   input wire logic [WIDTH-1:0] pc_wr_data,
   output logic [WIDTH-1:0] pc
);

   logic [WIDTH-1:0] regs_q [DEPTH];

   // ---------------------------------------------------------------
   // Architectural index to physical slot
   // ---------------------------------------------------------------
   function automatic logic [4:0] phys(ceb_pkg::ceb_mode_t m,
                                       logic [3:0] idx);
      logic [4:0] p;
      p = {1'b0, idx};
      if (m == ceb_pkg::MODE_FAST && idx >= ceb_pkg::IDX_FAST_LO
          && idx < ceb_pkg::IDX_PC) begin
         p = ceb_pkg::PHYS_FAST_BASE + {1'b0, idx - ceb_pkg::IDX_FAST_LO};
      end
      else if ((idx == ceb_pkg::IDX_SP || idx == ceb_pkg::IDX_LR)
               && m >= ceb_pkg::MODE_IRQ && m <= ceb_pkg::MODE_TRAP) begin
         p = ceb_pkg::PHYS_BANK_BASE
           + {1'b0, 3'(m - ceb_pkg::MODE_IRQ), 1'b0}
           + {4'h0, idx[0] ^ 1'b1};
      end
      return p;
   endfunction : phys

   // only fifteen plus the counter visible
   assign rd_data_a = regs_q[phys(mode, rd_idx_a)];
   assign rd_data_b = regs_q[phys(mode, rd_idx_b)];
   assign pc = regs_q[ceb_pkg::IDX_PC];

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // thirty-one general words
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_reg
         always_ff @(posedge clk) begin
            if (reset) begin
               regs_q[i] <= '0;
            end else if (pc_wr_en && i == ceb_pkg::IDX_PC) begin
               regs_q[i] <= pc_wr_data;
            end else if (wr_en && phys(wr_mode, wr_idx) == 5'(i)) begin
               regs_q[i] <= wr_data;
            end
         end
      end
   endgenerate

endmodule : ceb_bank_rf

// ===== bench/ceb_exc_unit_asserts.sv
/*
 * Port-level checks for the exception and banked register unit.
 * Assumes it is bound into ceb_exc_unit and shares its single clock.
 */
`timescale 1ns/1ps
module ceb_exc_unit_asserts #(
   parameter logic [31:0] VEC_BASE = 32'h0000_0000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Exceptions and status
   input wire logic fast_interrupt_req,
   input wire logic exc_taken,
   input wire ceb_pkg::ceb_exc_t exc_kind,
   input wire logic [31:0] pc,
   input wire ceb_pkg::ceb_status_t current_program_status,
   // Bus and debug
   input wire logic data_req,
   input wire logic fetch_gnt,
   input wire logic data_gnt,
   input wire logic bus_valid,
   input wire ceb_pkg::ceb_bus_req_t bus_cmd,
   input wire logic [3:0] bus_be,
   input wire logic bus_ready,
   input wire logic dbg_resume,
   input wire logic halted
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   chk_lane_byte: assert property (
      bus_valid && bus_cmd.size == ceb_pkg::SIZE_BYTE
      |-> bus_be == (4'h1 << bus_cmd.addr[1:0])) else $error("byte lanes");
   chk_lane_half: assert property (
      bus_valid && bus_cmd.size == ceb_pkg::SIZE_HALF
      |-> bus_be == (bus_cmd.addr[1] ? 4'hC : 4'h3)) else $error("half lanes");
   chk_data_first: assert property (
      data_req && bus_ready && !halted |-> data_gnt && !fetch_gnt)
      else $error("data not first");
   chk_entry_full: assert property (
      exc_taken |-> !current_program_status.compact
      && current_program_status.irq_mask) else $error("entry state");
   chk_fast_prio: assert property (
      exc_taken && exc_kind == ceb_pkg::EXC_IRQ
      |-> !$past(fast_interrupt_req)
      || $past(current_program_status.fast_mask))
      else $error("fast lost priority");
   chk_fast_bank: assert property (
      exc_taken && exc_kind == ceb_pkg::EXC_FAST
      |-> current_program_status.mode == ceb_pkg::MODE_FAST
      && current_program_status.fast_mask) else $error("fast mode");
   chk_vector_pc: assert property (
      exc_taken |-> pc == VEC_BASE + {27'h0, exc_kind, 2'b00})
      else $error("vector");
   chk_halt_quiet: assert property (
      halted && $past(halted) |-> !exc_taken && !fetch_gnt)
      else $error("activity while halted");
   chk_halt_resume: assert property (
      halted && dbg_resume |=> !halted) else $error("no resume");
endmodule : ceb_exc_unit_asserts

bind ceb_exc_unit ceb_exc_unit_asserts #(.VEC_BASE(VEC_BASE)) u_chk (.*);

// ===== bench/ceb_dbg_host.sv
/*
 * Far-side model: interrupt sources, debugger port and memory answer.
 * Assumes its tasks are called at a falling clock edge.
 */
`timescale 1ns/1ps
module ceb_dbg_host (
   // Clock and stall control
   input wire logic clk,
   input wire logic stall,
   // Interrupt sources
   output logic irq_req,
   output logic fast_interrupt_req,
   // Debug port
   output logic dbg_wr,
   output logic [1:0] dbg_sel,
   output logic [31:0] dbg_wdata,
   output logic dbg_resume,
   output logic [3:0] dbg_reg_idx,
   input wire logic [31:0] dbg_reg_data,
   output logic dbg_mem_req,
   output ceb_pkg::ceb_bus_req_t dbg_mem_cmd,
   // Memory answer
   output logic bus_ready
);
   // A stalled memory holds ready low, so the core must keep its request.
   assign bus_ready = !stall;

   initial begin
      {irq_req, fast_interrupt_req, dbg_wr, dbg_resume, dbg_mem_req} = '0;
      dbg_sel = 2'h0;
      dbg_wdata = 32'h0000_0000;
      dbg_reg_idx = 4'h0;
      dbg_mem_cmd = '0;
   end

   task automatic raise(input logic fast, input logic irq);
      fast_interrupt_req = fast;
      irq_req = irq;
   endtask : raise

   task automatic prog(input logic [1:0] sel, input logic [31:0] data);
      dbg_wr = 1'b1;
      dbg_sel = sel;
      dbg_wdata = data;
      @(negedge clk);
      dbg_wr = 1'b0;
      // Idle data is scrambled so nothing leans on a stale word.
      dbg_wdata = ~data;
      @(negedge clk);
   endtask : prog

   // Debugger memory access; the core answers it only while halted.
   task automatic mem(input logic on, input logic [31:0] addr);
      dbg_mem_req = on;
      dbg_mem_cmd.addr = addr;
   endtask : mem

   task automatic resume;
      dbg_resume = 1'b1;
      @(negedge clk);
      dbg_resume = 1'b0;
   endtask : resume

   task automatic peek(input logic [3:0] idx, output logic [31:0] data);
      dbg_reg_idx = idx;
      @(negedge clk);
      data = dbg_reg_data;
   endtask : peek
endmodule : ceb_dbg_host

// ===== bench/core_exception_banking_tb.sv
/*
 * Self-checking bench for the exception and banked register unit.
 * Assumes the far-side model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module core_exception_banking_tb;
   localparam logic [31:0] VB = 32'h0000_0100;
   logic clk, reset, stall, irq_req, fast_interrupt_req;
   logic abort_req, undef_req, software_trap_req, exc_return, exc_taken;
   logic wr_en, pc_wr_en, status_wr_en, fetch_req, fetch_gnt, data_req;
   logic data_gnt, bus_valid, bus_ready, dbg_wr, dbg_resume, dbg_mem_req;
   logic dbg_mem_gnt, halted;
   logic [1:0] dbg_sel;
   logic [3:0] rd_idx_a, rd_idx_b, wr_idx, bus_be, dbg_reg_idx;
   logic [31:0] ret_addr, rd_data_a, rd_data_b, wr_data, pc_wr_data, pc;
   logic [31:0] fetch_addr, dbg_wdata, dbg_reg_data, v;
   ceb_pkg::ceb_exc_t exc_kind;
   ceb_pkg::ceb_status_t status_wr_data, current_program_status, saved_status;
   ceb_pkg::ceb_bus_req_t data_cmd, bus_cmd, dbg_mem_cmd;
   ceb_pkg::ceb_mode_t mode_of [6] = '{ceb_pkg::MODE_USER,
      ceb_pkg::MODE_ABORT, ceb_pkg::MODE_FAST, ceb_pkg::MODE_IRQ,
      ceb_pkg::MODE_UNDEF, ceb_pkg::MODE_TRAP};
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   ceb_exc_unit #(.VEC_BASE(VB)) u_dut (.*);
   ceb_dbg_host u_host (.*);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         results();
      end
   end

   task automatic results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic rd(input logic [3:0] i, input logic [31:0] e);
      rd_idx_a = i;
      rd_idx_b = i;
      #1;
      cmp(rd_data_a, e);
      cmp(rd_data_b, e);
      @(negedge clk);
   endtask : rd

   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      {wr_en, wr_idx, wr_data} = {1'b1, i, d};
      @(negedge clk);
      wr_en = 1'b0;
      @(negedge clk);
   endtask : wr

   task automatic set_st(input ceb_pkg::ceb_mode_t m, input logic [3:0] f);
      status_wr_data = '{flags: f, rsvd: 22'h0, irq_mask: 1'b0,
         fast_mask: 1'b0, compact: 1'b1, mode: m};
      status_wr_en = 1'b1;
      @(negedge clk);
      status_wr_en = 1'b0;
      @(negedge clk);
   endtask : set_st

   task automatic wait_exc(input ceb_pkg::ceb_exc_t k);
      for (int i = 0; i < 8 && exc_taken !== 1'b1; i++) begin
         @(negedge clk);
      end
      cmp(exc_taken, 1'b1);
      cmp(exc_kind, k);
      cmp(current_program_status.mode, mode_of[k]);
      cmp(current_program_status.compact, 1'b0);
      cmp(saved_status, status_wr_data);
      cmp(pc, VB + {k, 2'b00});
      rd(4'hE, ret_addr);
   endtask : wait_exc

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_bus;
      logic [3:0] be [3] = '{4'h4, 4'hC, 4'hF};
      stall = 1'b1;
      fetch_addr = 32'h0000_0040;
      fetch_req = 1'b1;
      data_cmd = '{addr: 32'h0000_0402, wdata: 32'hCAFE_F00D, we: 1'b1,
         size: ceb_pkg::SIZE_BYTE};
      data_req = 1'b1;
      #1;
      cmp(data_gnt, 1'b0);
      @(negedge clk);
      stall = 1'b0;
      for (int s = 0; s < 3; s++) begin
         data_cmd.size = ceb_pkg::ceb_size_t'(s);
         #1;
         cmp(bus_be, be[s]);
         cmp(data_gnt, 1'b1);
         cmp(fetch_gnt, 1'b0);
         cmp(bus_cmd.addr, 32'h0000_0402);
         @(negedge clk);
      end
      data_req = 1'b0;
      #1;
      cmp(fetch_gnt, 1'b1);
      cmp(bus_cmd.addr, 32'h0000_0040);
      @(negedge clk);
      fetch_req = 1'b0;
   endtask : t_bus

   task automatic t_kinds;
      for (int k = 1; k < 6; k++) begin
         set_st(ceb_pkg::MODE_SYSTEM, 4'h0);
         ret_addr = 32'h0000_1000 + k;
         {abort_req, undef_req, software_trap_req} = {k == 1, k == 4, k == 5};
         u_host.raise(k == 2, k == 2 || k == 3);
         @(negedge clk);
         {abort_req, undef_req, software_trap_req} = 3'b000;
         wait_exc(ceb_pkg::ceb_exc_t'(k));
         u_host.raise(1'b0, 1'b0);
      end
   endtask : t_kinds

   task automatic t_bank;
      set_st(ceb_pkg::MODE_SYSTEM, 4'h0);
      wr(4'hD, 32'h5555_0000);
      wr(4'h8, 32'h8888_0000);
      ret_addr = 32'hABCD_0004;
      u_host.raise(1'b1, 1'b0);
      wait_exc(ceb_pkg::EXC_FAST);
      u_host.raise(1'b0, 1'b0);
      rd(4'h8, 32'h0);
      rd(4'hD, 32'h0);
      wr(4'h8, 32'h1234_0000);
      exc_return = 1'b1;
      @(negedge clk);
      exc_return = 1'b0;
      rd(4'h8, 32'h8888_0000);
      rd(4'hD, 32'h5555_0000);
      cmp(current_program_status.mode, ceb_pkg::MODE_SYSTEM);
      {pc_wr_en, pc_wr_data} = {1'b1, 32'h0000_2468};
      @(negedge clk);
      pc_wr_en = 1'b0;
      cmp(pc, 32'h0000_2468);
   endtask : t_bank

   task automatic t_debug;
      wr(4'h3, 32'h3333_0003);
      u_host.prog(ceb_pkg::DBG_BKPT_ADDR, 32'h0000_0200);
      u_host.prog(ceb_pkg::DBG_BKPT_CTRL, 32'h0000_0001);
      fetch_addr = 32'h0000_0200;
      fetch_req = 1'b1;
      #1;
      cmp(fetch_gnt, 1'b0);
      @(negedge clk);
      cmp(halted, 1'b1);
      u_host.peek(4'h3, v);
      cmp(v, 32'h3333_0003);
      u_host.mem(1'b1, 32'h0000_0404);
      #1;
      cmp(dbg_mem_gnt, 1'b1);
      cmp(bus_valid, 1'b1);
      cmp(bus_cmd.addr, 32'h0000_0404);
      @(negedge clk);
      u_host.resume();
      #1;
      cmp(fetch_gnt, 1'b1);
      cmp(dbg_mem_gnt, 1'b0);
      @(negedge clk);
      fetch_req = 1'b0;
      u_host.mem(1'b0, 32'h0000_0000);
      u_host.prog(ceb_pkg::DBG_WATCH_ADDR, 32'h0000_0300);
      u_host.prog(ceb_pkg::DBG_WATCH_CTRL, 32'h0000_0001);
      data_cmd.addr = 32'h0000_0300;
      data_req = 1'b1;
      @(negedge clk);
      data_req = 1'b0;
      cmp(halted, 1'b1);
      u_host.resume();
      cmp(halted, 1'b0);
   endtask : t_debug

   task automatic t_user;
      set_st(ceb_pkg::MODE_USER, 4'h0);
      set_st(ceb_pkg::MODE_SYSTEM, 4'hA);
      cmp(current_program_status.mode, ceb_pkg::MODE_USER);
      cmp(current_program_status.flags, 4'hA);
      cmp(saved_status, 32'h0);
      rd(4'hD, 32'h5555_0000);
      // Only the flags landed, so the word saved on entry is still user mode.
      status_wr_data.mode = ceb_pkg::MODE_USER;
      software_trap_req = 1'b1;
      @(negedge clk);
      software_trap_req = 1'b0;
      wait_exc(ceb_pkg::EXC_TRAP);
   endtask : t_user

   initial begin
      reset = 1'b1;
      {stall, abort_req, undef_req, software_trap_req, exc_return} = '0;
      {wr_en, pc_wr_en, status_wr_en, fetch_req, data_req} = '0;
      {rd_idx_a, rd_idx_b, wr_idx} = '0;
      {ret_addr, wr_data, pc_wr_data, fetch_addr} = '0;
      status_wr_data = '0;
      data_cmd = '0;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      cmp(current_program_status, ceb_pkg::STATUS_RESET);
      cmp(halted, 1'b0);
      t_bus();
      t_kinds();
      t_bank();
      t_debug();
      t_user();
      results();
   end
endmodule : core_exception_banking_tb
